// ### motion_irq_map.vh
/*
  register offsets, field positions, reset values and timing counts of the
  motion engine interrupt block; assumes a 32-bit AHB-Lite slave at hclk.
*/
// Operation
// - tilt engine runs and interrupts only while its enable bit is set
// - wake-up engine runs only while its enable bit is set
// - back-to-sleep engine runs only while its enable bit is set
// - writing 1 to manual sleep forces sleep and clears the wake flag
// - release read clears latched interrupt and wake/sleep source flags
// - wake-up fires after an unmasked axis stays above threshold until timer end
// - each engine timer counts ticks of that engine's own data rate, except back-to-sleep, which counts wake-up ticks
// - tilt state reported only after persisting until timer end; change restarts
// - tap engine runs only while its enable bit is set
// - tap qualifies only with index between low and high limits
// - free-fall engine runs only while its enable bit is set
// - free-fall depends on programmable threshold and debounce count
// - detections gated by wake axis, tap and tilt state masks
// - latched mode: release read clears all sources and summary bit
// - pulse mode: pin pulses about 50 us then clears itself
`ifndef MOTION_IRQ_MAP_VH
`define MOTION_IRQ_MAP_VH

`define OFS_CTRL_ONE        7'h00
`define OFS_CTRL_TWO        7'h04
`define OFS_CTRL_FOUR       7'h08
`define OFS_CTRL_FIVE       7'h0c
`define OFS_IRQ_CTRL_ONE    7'h10
`define OFS_IRQ_CTRL_TWO    7'h14
`define OFS_IRQ_CTRL_THREE  7'h18
`define OFS_TILT_TIMER      7'h1c
`define OFS_WAKE_TIMER      7'h20
`define OFS_TAP_LOW         7'h24
`define OFS_TAP_HIGH        7'h28
`define OFS_FALL_CTRL       7'h2c
`define OFS_FALL_THRESH     7'h30
`define OFS_FALL_COUNT      7'h34
`define OFS_SLEEP_TIMER     7'h38
`define OFS_STATUS          7'h3c
`define OFS_IRQ_STATUS_TWO  7'h40
`define OFS_IRQ_STATUS_THREE 7'h44
`define OFS_IRQ_RELEASE     7'h48
`define OFS_EVT_STATUS      7'h4c
`define OFS_EVT_MASK        7'h50
`define OFS_TILT_POS        7'h54
`define OFS_TAP_WINDOW      7'h58

`define BIT_TILT_EN         0
`define BIT_TAP_EN          2
`define BIT_WAKE_EN         1
`define BIT_SLEEP_EN        0
`define BIT_MAN_SLEEP       0
`define BIT_PIN_PULSE       3
`define BIT_PIN_HIGH        4
`define BIT_PIN_EN          5
`define BIT_FALL_EN         7
`define BIT_STAT_WAKE       0
`define BIT_STAT_INT        4
`define BIT_SRC_TILT        0
`define BIT_SRC_STAP        2
`define BIT_SRC_DTAP        3
`define BIT_SRC_FALL        7
`define BIT_SRC_SLEEP       0
`define BIT_SRC_WAKE        1

`define RST_CTRL_TWO        8'h3f
`define RST_IRQ_CTRL_ONE    8'h10
`define RST_AXIS_MASK       8'h3f
`define RST_TIMER           8'h01
`define RST_TAP_LOW         8'h1a
`define RST_TAP_HIGH        8'hb6
`define RST_FALL_THRESH     8'h08
`define RST_FALL_COUNT      8'h04
`define RST_TAP_WINDOW      8'h08

`define CLK_PERIOD_NS       40
`define PIN_PULSE_NS        50000
`define PIN_PULSE_CYCLES    ((`PIN_PULSE_NS) / (`CLK_PERIOD_NS))

`endif

// ### qualify_timer.v
/*
  persistence qualifier: counts data-rate ticks while a condition holds and
  its key is unchanged, and pulses once when the programmed count is met.
  assumes tick is a one-cycle strobe at the engine's own data rate.
*/
`timescale 1ns/100ps
`default_nettype none
module qualify_timer #(
  parameter KW = 6,
  parameter TW = 8
) (
  input  wire          hclk,
  input  wire          hresetn,
  input  wire          enable,
  input  wire          tick,
  input  wire          cond,
  input  wire [KW-1:0] key,
  input  wire [TW-1:0] limit,
  output reg           fire_ff
);
  reg [TW-1:0] cnt_ff;
  reg [KW-1:0] key_ff;
  reg          done_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff  <= {TW{1'b0}};
      key_ff  <= {KW{1'b0}};
      done_ff <= 1'b0;
      fire_ff <= 1'b0;
    end else begin
      key_ff  <= key;
      fire_ff <= 1'b0;
      if (!enable) begin
        cnt_ff  <= {TW{1'b0}};
        done_ff <= 1'b0;
      end else if (!cond || key != key_ff) begin
        cnt_ff  <= {TW{1'b0}};
        done_ff <= 1'b0;
      end else if (tick && !done_ff) begin
        if (cnt_ff + {{(TW-1){1'b0}}, 1'b1} >= limit) begin
          fire_ff <= 1'b1;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + {{(TW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // qualify_timer
`default_nettype wire

// ### motion_engine_interrupt_control.v
/*
  motion engine interrupt control: AHB-Lite register file, enable and mask
  gating of tilt, wake-up, back-to-sleep, tap and free-fall engines, source
  flags, physical interrupt pin and a maskable level irq.
  assumes detection inputs and data-rate ticks are synchronous to hclk.
*/
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "motion_irq_map.vh"
module motion_engine_interrupt_control (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout_ff,
  output reg  [31:0] hrdata_ff,
  output reg         hresp_ff,
  input  wire        tilt_tick,
  input  wire        wake_tick,
  input  wire        tap_tick,
  input  wire        fall_tick,
  input  wire [5:0]  tilt_orient,
  input  wire [5:0]  axis_above,
  input  wire        motion_quiet,
  input  wire        tap_strobe,
  input  wire [5:0]  tap_dir,
  input  wire [7:0]  tap_index,
  input  wire [7:0]  fall_magnitude,
  output reg         int_pin_ff,
  output reg         irq_ff
);
  reg  [7:0]  ctrl_one_ff;
  reg  [7:0]  ctrl_two_ff;
  reg  [7:0]  ctrl_four_ff;
  reg  [7:0]  irq_ctrl_one_ff;
  reg  [7:0]  irq_ctrl_two_ff;
  reg  [7:0]  irq_ctrl_three_ff;
  reg  [7:0]  tilt_timer_ff;
  reg  [7:0]  wake_timer_ff;
  reg  [7:0]  tap_low_ff;
  reg  [7:0]  tap_index_high_limit_ff;
  reg  [7:0]  fall_control_register_ff;
  reg  [7:0]  fall_threshold_register_ff;
  reg  [7:0]  fall_debounce_counter_ff;
  reg  [7:0]  sleep_timer_ff;
  reg  [7:0]  tap_window_ff;
  reg  [7:0]  irq_status_two_ff;
  reg  [7:0]  irq_status_three_ff;
  reg  [7:0]  evt_status_ff;
  reg  [7:0]  evt_mask_ff;
  reg  [5:0]  tilt_pos_ff;
  reg         awake_ff;
  reg         summary_ff;
  reg         pend_ff;
  reg         pwrite_ff;
  reg  [6:0]  paddr_ff;
  reg  [10:0] pulse_cnt_ff;
  reg         tap_armed_ff;
  reg  [7:0]  tap_win_cnt_ff;
  reg  [5:0]  tap_dir_ff;
  reg  [31:0] rd_word;

  wire tilt_en  = ctrl_one_ff[`BIT_TILT_EN];
  wire tap_en   = ctrl_one_ff[`BIT_TAP_EN];
  wire wake_en  = ctrl_four_ff[`BIT_WAKE_EN];
  wire sleep_en = ctrl_four_ff[`BIT_SLEEP_EN];
  wire fall_en  = fall_control_register_ff[`BIT_FALL_EN];

  wire        take     = hsel & htrans[1] & hready;
  wire        wr_cyc   = pend_ff & pwrite_ff;
  wire        rd_cyc   = pend_ff & ~pwrite_ff;

  function sel_hit;
    input [6:0] a;
    input [6:0] ofs;
    begin
      sel_hit = (a == ofs);
    end
  endfunction

  wire man_sleep   = wr_cyc & sel_hit(paddr_ff, `OFS_CTRL_FIVE) & hwdata[`BIT_MAN_SLEEP];
  wire release_rd  = rd_cyc & sel_hit(paddr_ff, `OFS_IRQ_RELEASE);
  wire evt_rd      = rd_cyc & sel_hit(paddr_ff, `OFS_EVT_STATUS);

  // engine qualification
  wire [5:0] tilt_masked = tilt_orient & ctrl_two_ff[5:0];
  wire       tilt_fire;
  wire       wake_fire;
  wire       sleep_fire;
  wire       fall_fire;
  wire       wake_cond = |(axis_above & irq_ctrl_two_ff[5:0]);
  wire       fall_cond = fall_magnitude < fall_threshold_register_ff;

  qualify_timer #(.KW(6), .TW(8)) u_tilt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (tilt_en),
    .tick    (tilt_tick),
    .cond    (|tilt_masked),
    .key     (tilt_orient),
    .limit   (tilt_timer_ff),
    .fire_ff (tilt_fire)
  );

  qualify_timer #(.KW(1), .TW(8)) u_wake (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (wake_en & ~awake_ff),
    .tick    (wake_tick),
    .cond    (wake_cond),
    .key     (1'b0),
    .limit   (wake_timer_ff),
    .fire_ff (wake_fire)
  );

  // back-to-sleep times quiet motion at the wake-up engine's data rate
  qualify_timer #(.KW(1), .TW(8)) u_sleep (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (sleep_en & awake_ff),
    .tick    (wake_tick),
    .cond    (motion_quiet),
    .key     (1'b0),
    .limit   (sleep_timer_ff),
    .fire_ff (sleep_fire)
  );

  qualify_timer #(.KW(1), .TW(8)) u_fall (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (fall_en),
    .tick    (fall_tick),
    .cond    (fall_cond),
    .key     (1'b0),
    .limit   (fall_debounce_counter_ff),
    .fire_ff (fall_fire)
  );

  // tap: index window and direction mask, then a double-tap window in tap ticks
  wire tap_ok = tap_en & tap_strobe & (|(tap_dir & irq_ctrl_three_ff[5:0]))
              & (tap_index > tap_low_ff) & (tap_index < tap_index_high_limit_ff);
  reg  stap_fire;
  reg  dtap_fire;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_armed_ff   <= 1'b0;
      tap_win_cnt_ff <= 8'h00;
      tap_dir_ff     <= 6'h00;
      stap_fire      <= 1'b0;
      dtap_fire      <= 1'b0;
    end else begin
      stap_fire <= 1'b0;
      dtap_fire <= 1'b0;
      if (!tap_en) begin
        tap_armed_ff   <= 1'b0;
        tap_win_cnt_ff <= 8'h00;
      end else if (tap_ok && tap_armed_ff) begin
        dtap_fire    <= 1'b1;
        tap_armed_ff <= 1'b0;
      end else if (tap_ok) begin
        tap_armed_ff   <= 1'b1;
        tap_win_cnt_ff <= 8'h00;
        tap_dir_ff     <= tap_dir;
      end else if (tap_armed_ff && tap_tick) begin
        if (tap_win_cnt_ff + 8'h01 >= tap_window_ff) begin
          stap_fire    <= 1'b1;
          tap_armed_ff <= 1'b0;
        end else begin
          tap_win_cnt_ff <= tap_win_cnt_ff + 8'h01;
        end
      end
    end
  end

  wire [7:0] ins2_set = ({7'h00, tilt_fire} << `BIT_SRC_TILT)
                      | ({7'h00, stap_fire} << `BIT_SRC_STAP)
                      | ({7'h00, dtap_fire} << `BIT_SRC_DTAP)
                      | ({7'h00, fall_fire} << `BIT_SRC_FALL);
  wire [7:0] irq_status_three_set = ({7'h00, wake_fire} << `BIT_SRC_WAKE)
                      | ({7'h00, sleep_fire} << `BIT_SRC_SLEEP);
  wire       any_evt  = |ins2_set | |irq_status_three_set;
  wire [7:0] evt_set  = {2'b00, sleep_fire, wake_fire, fall_fire, dtap_fire, stap_fire, tilt_fire};

  // bus: one wait state per transfer, so reads see writes made just before
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff      <= 1'b0;
      pwrite_ff    <= 1'b0;
      paddr_ff     <= 7'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
      if (pend_ff) begin
        pend_ff      <= 1'b0;
        hreadyout_ff <= 1'b1;
      end else if (take) begin
        pend_ff      <= 1'b1;
        pwrite_ff    <= hwrite;
        paddr_ff     <= {haddr[6:2], 2'b00};
        hreadyout_ff <= 1'b0;
      end
    end
  end

  always @* begin
    rd_word = 32'h0000_0000;
    case (paddr_ff)
      `OFS_CTRL_ONE:         rd_word[7:0] = ctrl_one_ff;
      `OFS_CTRL_TWO:         rd_word[7:0] = ctrl_two_ff;
      `OFS_CTRL_FOUR:        rd_word[7:0] = ctrl_four_ff;
      `OFS_IRQ_CTRL_ONE:     rd_word[7:0] = irq_ctrl_one_ff;
      `OFS_IRQ_CTRL_TWO:     rd_word[7:0] = irq_ctrl_two_ff;
      `OFS_IRQ_CTRL_THREE:   rd_word[7:0] = irq_ctrl_three_ff;
      `OFS_TILT_TIMER:       rd_word[7:0] = tilt_timer_ff;
      `OFS_WAKE_TIMER:       rd_word[7:0] = wake_timer_ff;
      `OFS_TAP_LOW:          rd_word[7:0] = tap_low_ff;
      `OFS_TAP_HIGH:         rd_word[7:0] = tap_index_high_limit_ff;
      `OFS_FALL_CTRL:        rd_word[7:0] = fall_control_register_ff;
      `OFS_FALL_THRESH:      rd_word[7:0] = fall_threshold_register_ff;
      `OFS_FALL_COUNT:       rd_word[7:0] = fall_debounce_counter_ff;
      `OFS_SLEEP_TIMER:      rd_word[7:0] = sleep_timer_ff;
      `OFS_TAP_WINDOW:       rd_word[7:0] = tap_window_ff;
      `OFS_STATUS: begin
        rd_word[`BIT_STAT_WAKE] = awake_ff;
        rd_word[`BIT_STAT_INT]  = summary_ff;
      end
      `OFS_IRQ_STATUS_TWO:   rd_word[7:0] = irq_status_two_ff;
      `OFS_IRQ_STATUS_THREE: rd_word[7:0] = irq_status_three_ff;
      `OFS_EVT_STATUS:       rd_word[7:0] = evt_status_ff;
      `OFS_EVT_MASK:         rd_word[7:0] = evt_mask_ff;
      `OFS_TILT_POS:         rd_word[5:0] = tilt_pos_ff;
      `OFS_IRQ_RELEASE:      rd_word[7:0] = {irq_status_two_ff[7], irq_status_three_ff[6:0]};
      default:               rd_word = 32'h0000_0000;
    endcase
  end

  // register file; hardware set wins over any clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff                  <= 32'h0000_0000;
      ctrl_one_ff                <= 8'h00;
      ctrl_two_ff                <= `RST_CTRL_TWO;
      ctrl_four_ff               <= 8'h00;
      irq_ctrl_one_ff            <= `RST_IRQ_CTRL_ONE;
      irq_ctrl_two_ff            <= `RST_AXIS_MASK;
      irq_ctrl_three_ff          <= `RST_AXIS_MASK;
      tilt_timer_ff              <= `RST_TIMER;
      wake_timer_ff              <= `RST_TIMER;
      tap_low_ff                 <= `RST_TAP_LOW;
      tap_index_high_limit_ff    <= `RST_TAP_HIGH;
      fall_control_register_ff   <= 8'h00;
      fall_threshold_register_ff <= `RST_FALL_THRESH;
      fall_debounce_counter_ff   <= `RST_FALL_COUNT;
      sleep_timer_ff             <= `RST_TIMER;
      tap_window_ff              <= `RST_TAP_WINDOW;
      evt_mask_ff                <= 8'h00;
    end else begin
      if (rd_cyc) begin
        hrdata_ff <= rd_word;
      end
      if (wr_cyc) begin
        case (paddr_ff)
          `OFS_CTRL_ONE:       ctrl_one_ff                <= hwdata[7:0];
          `OFS_CTRL_TWO:       ctrl_two_ff                <= hwdata[7:0];
          `OFS_CTRL_FOUR:      ctrl_four_ff               <= hwdata[7:0];
          `OFS_IRQ_CTRL_ONE:   irq_ctrl_one_ff            <= hwdata[7:0];
          `OFS_IRQ_CTRL_TWO:   irq_ctrl_two_ff            <= hwdata[7:0];
          `OFS_IRQ_CTRL_THREE: irq_ctrl_three_ff          <= hwdata[7:0];
          `OFS_TILT_TIMER:     tilt_timer_ff              <= hwdata[7:0];
          `OFS_WAKE_TIMER:     wake_timer_ff              <= hwdata[7:0];
          `OFS_TAP_LOW:        tap_low_ff                 <= hwdata[7:0];
          `OFS_TAP_HIGH:       tap_index_high_limit_ff    <= hwdata[7:0];
          `OFS_FALL_CTRL:      fall_control_register_ff   <= hwdata[7:0];
          `OFS_FALL_THRESH:    fall_threshold_register_ff <= hwdata[7:0];
          `OFS_FALL_COUNT:     fall_debounce_counter_ff   <= hwdata[7:0];
          `OFS_SLEEP_TIMER:    sleep_timer_ff             <= hwdata[7:0];
          `OFS_TAP_WINDOW:     tap_window_ff              <= hwdata[7:0];
          `OFS_EVT_MASK:       evt_mask_ff                <= hwdata[7:0];
          default:             evt_mask_ff                <= evt_mask_ff;
        endcase
      end
    end
  end

  // source flags, wake state, tilt position
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_two_ff   <= 8'h00;
      irq_status_three_ff <= 8'h00;
      evt_status_ff       <= 8'h00;
      summary_ff          <= 1'b0;
      awake_ff            <= 1'b0;
      tilt_pos_ff         <= 6'h00;
    end else begin
      irq_status_two_ff   <= (release_rd ? 8'h00 : irq_status_two_ff) | ins2_set;
      irq_status_three_ff <= (release_rd ? 8'h00 : irq_status_three_ff) | irq_status_three_set;
      evt_status_ff       <= (evt_rd ? 8'h00 : evt_status_ff) | evt_set;
      summary_ff          <= (release_rd ? 1'b0 : summary_ff) | any_evt;
      if (wake_fire) begin
        awake_ff <= 1'b1;
      end else if (sleep_fire || man_sleep) begin
        awake_ff <= 1'b0;
      end
      if (tilt_fire) begin
        tilt_pos_ff <= tilt_orient;
      end
    end
  end

  // physical pin: latched follows the summary bit, pulse mode self-clears
  wire pin_en    = irq_ctrl_one_ff[`BIT_PIN_EN];
  wire pin_pulse = irq_ctrl_one_ff[`BIT_PIN_PULSE];
  wire pin_high  = irq_ctrl_one_ff[`BIT_PIN_HIGH];
  wire pin_act   = pin_en & (pin_pulse ? (pulse_cnt_ff != 11'h000) : summary_ff);
  localparam integer PULSE_CYCLES = `PIN_PULSE_CYCLES;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt_ff <= 11'h000;
      int_pin_ff   <= 1'b0;
      irq_ff       <= 1'b0;
    end else begin
      if (any_evt && pin_pulse) begin
        pulse_cnt_ff <= PULSE_CYCLES[10:0];
      end else if (pulse_cnt_ff != 11'h000) begin
        pulse_cnt_ff <= pulse_cnt_ff - 11'h001;
      end
      int_pin_ff <= pin_high ? pin_act : ~pin_act;
      irq_ff     <= |(evt_status_ff & evt_mask_ff);
    end
  end
endmodule // motion_engine_interrupt_control
`default_nettype wire

// ### motion_irq_checker.sv
/*
  port checker of the motion engine interrupt block.
  assumes one hclk domain with active-low asynchronous hresetn.
*/
`timescale 1ns/100ps
`default_nettype none
module motion_irq_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout_ff,
  input wire logic [31:0] hrdata_ff,
  input wire logic        hresp_ff,
  input wire logic        tilt_tick,
  input wire logic        wake_tick,
  input wire logic        tap_tick,
  input wire logic        fall_tick,
  input wire logic        tap_strobe,
  input wire logic        int_pin_ff,
  input wire logic        irq_ff
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic evt_in;
  assign take   = hsel && htrans[1] && hready;
  assign evt_in = tilt_tick | wake_tick | tap_tick | fall_tick | tap_strobe;
  property p_one_wait;
    take |=> !hreadyout_ff ##1 hreadyout_ff;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
  property p_okay;
    hresp_ff == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rdata_narrow;
    hrdata_ff[31:8] == 24'h0;
  endproperty
  a_rdata_narrow: assert property (p_rdata_narrow) else $error("read data upper bits set");
  property p_rdata_hold;
    $changed(hrdata_ff) |-> $past(take && !hwrite, 2);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  // an irq edge needs an engine tick, a tap strobe or a register write shortly before
  property p_irq_cause;
    $rose(irq_ff) |-> $past(evt_in, 2) || $past(evt_in, 3) || $past(evt_in, 4)
      || $past(take && hwrite, 3) || $past(take && hwrite, 4);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_irq_sticky;
    $fell(irq_ff) |-> $past(take, 3);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped by itself");
  property p_evt_clear;
    take && !hwrite && haddr[6:2] == 5'h13 && !evt_in ##1 (!evt_in)[*3] |-> !irq_ff;
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("status read left irq high");
  // latched pin settles once the release read has cleared the summary
  property p_release_pin;
    take && !hwrite && haddr[6:2] == 5'h12 && !evt_in ##1 (!evt_in)[*5]
      |-> $stable(int_pin_ff);
  endproperty
  a_release_pin: assert property (p_release_pin) else $error("pin moving after release");
  c_irq: cover property ($rose(irq_ff));
  c_pin: cover property ($fell(int_pin_ff));
  c_rel: cover property (take && !hwrite && haddr[6:2] == 5'h12);
endmodule // motion_irq_checker
`default_nettype wire

// ### motion_host_model.sv
/*
  host microcontroller model: single-word AHB-Lite master.
  assumes hready is the one slave's hreadyout; counts its own timeouts.
*/
`timescale 1ns/100ps
`default_nettype none
module motion_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  int n_to;
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; n_to = 0;
  end
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 64) n_to++;
  endtask
  task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1; haddr <= {25'h0, a}; htrans <= 2'b10; hwrite <= w;
    wait_ready();
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    wait_ready();
    q = hrdata;
    // released data is inverted so a stale value never looks valid
    hwdata <= ~d;
  endtask
endmodule // motion_host_model
`default_nettype wire

// ### motion_engine_interrupt_control_tb_top.sv
/*
  self-checking bench of the motion engine interrupt block.
  assumes the register map header and a 25 MHz hclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "motion_irq_map.vh"
module motion_engine_interrupt_control_tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, int_pin, irq;
  logic motion_quiet, tap_strobe;
  logic [31:0] haddr, hwdata, hrdata, q, pin_hi;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  tk;
  logic [5:0]  tilt_orient, axis_above, tap_dir;
  logic [7:0]  tap_index, fall_magnitude, v;
  int n_mismatch, checks;
  logic [6:0] ofs [13] = '{`OFS_CTRL_ONE, `OFS_CTRL_TWO, `OFS_IRQ_CTRL_ONE, `OFS_IRQ_CTRL_TWO,
    `OFS_IRQ_CTRL_THREE, `OFS_TILT_TIMER, `OFS_WAKE_TIMER, `OFS_TAP_LOW, `OFS_TAP_HIGH,
    `OFS_FALL_THRESH, `OFS_FALL_COUNT, `OFS_TAP_WINDOW, `OFS_STATUS};
  logic [7:0] rv [13] = '{8'h00, `RST_CTRL_TWO, `RST_IRQ_CTRL_ONE, `RST_AXIS_MASK,
    `RST_AXIS_MASK, `RST_TIMER, `RST_TIMER, `RST_TAP_LOW, `RST_TAP_HIGH, `RST_FALL_THRESH,
    `RST_FALL_COUNT, `RST_TAP_WINDOW, 8'h00};
  motion_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  motion_engine_interrupt_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout_ff(hreadyout), .hrdata_ff(hrdata), .hresp_ff(hresp),
    .tilt_tick(tk[0]), .wake_tick(tk[1]), .tap_tick(tk[2]), .fall_tick(tk[3]),
    .tilt_orient(tilt_orient), .axis_above(axis_above), .motion_quiet(motion_quiet),
    .tap_strobe(tap_strobe), .tap_dir(tap_dir), .tap_index(tap_index),
    .fall_magnitude(fall_magnitude), .int_pin_ff(int_pin), .irq_ff(irq));
  always #20 hclk = ~hclk;
  always @(posedge hclk) if (int_pin === 1'b1) pin_hi <= pin_hi + 32'h1;
  task automatic complete_run();
    n_mismatch += host.n_to;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, q);
    if (host.n_to > 0) complete_run();
  endtask
  task automatic rd(input logic [6:0] a);
    host.xfer(1'b0, a, 32'h0, q);
    if (host.n_to > 0) complete_run();
  endtask
  task automatic chk(input logic [6:0] a, input logic [7:0] e);
    rd(a);
    cmp(q, {24'h0, e});
  endtask
  task automatic tick(input int i, input int n);
    repeat (n) begin
      tk[i] <= 1'b1;
      @(posedge hclk);
      tk[i] <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask
  task automatic tap(input logic [7:0] x);
    tap_index <= x;
    tap_strobe <= 1'b1;
    @(posedge hclk);
    tap_strobe <= 1'b0;
    @(posedge hclk);
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    hclk = 1'b0; hresetn = 1'b0; tk = 4'h0; tilt_orient = 6'h02; axis_above = 6'h0;
    motion_quiet = 1'b0; tap_strobe = 1'b0; tap_dir = 6'h01; tap_index = 8'h0;
    fall_magnitude = 8'hff; pin_hi = 32'h0; n_mismatch = 0; checks = 0;
    void'($urandom(32'hc948));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 13; i++) chk(ofs[i], rv[i]);
    chk(7'h7c, 8'h00);
    wr(`OFS_EVT_MASK, 8'h3f);
    wr(`OFS_IRQ_CTRL_ONE, 8'h30);
    // wake-up: disabled, masked axis, broken hold, then full hold
    wr(`OFS_WAKE_TIMER, 8'h03);
    wr(`OFS_IRQ_CTRL_TWO, 8'h01);
    axis_above <= 6'h01;
    tick(1, 4); settle();
    chk(`OFS_IRQ_STATUS_THREE, 8'h00);
    wr(`OFS_CTRL_FOUR, 8'h02);
    axis_above <= 6'h02;
    tick(1, 4); settle();
    chk(`OFS_IRQ_STATUS_THREE, 8'h00);
    axis_above <= 6'h01;
    tick(1, 2);
    axis_above <= 6'h00;
    tick(1, 1);
    axis_above <= 6'h01;
    tick(1, 2); settle();
    chk(`OFS_IRQ_STATUS_THREE, 8'h00);
    tick(1, 1); settle();
    cmp(int_pin, 1'b1);
    chk(`OFS_IRQ_STATUS_THREE, 8'h02);
    chk(`OFS_STATUS, 8'h11);
    rd(`OFS_IRQ_RELEASE); settle();
    chk(`OFS_IRQ_STATUS_THREE, 8'h00);
    chk(`OFS_STATUS, 8'h01);
    cmp(int_pin, 1'b0);
    axis_above <= 6'h00;
    wr(`OFS_CTRL_FIVE, 8'h01); settle();
    chk(`OFS_STATUS, 8'h00);
    rd(`OFS_EVT_STATUS); settle();
    cmp(irq, 1'b0);
    wr(`OFS_CTRL_FOUR, 8'h03);
    axis_above <= 6'h01;
    tick(1, 3);
    axis_above <= 6'h00;
    motion_quiet <= 1'b1;
    tick(1, 1); settle();
    chk(`OFS_IRQ_STATUS_THREE, 8'h03);
    chk(`OFS_STATUS, 8'h10);
    wr(`OFS_CTRL_FOUR, 8'h00);
    // tilt: disabled ticks, restart by re-enable, restart by change
    wr(`OFS_TILT_TIMER, 8'h03);
    tick(0, 4); settle();
    chk(`OFS_IRQ_STATUS_TWO, 8'h00);
    wr(`OFS_CTRL_ONE, 8'h01);
    tick(0, 2);
    wr(`OFS_CTRL_ONE, 8'h00);
    wr(`OFS_CTRL_ONE, 8'h01);
    tick(0, 2); settle();
    chk(`OFS_IRQ_STATUS_TWO, 8'h00);
    tilt_orient <= 6'h04;
    settle();
    tick(0, 2); settle();
    chk(`OFS_IRQ_STATUS_TWO, 8'h00);
    tick(0, 1); settle();
    chk(`OFS_IRQ_STATUS_TWO, 8'h01);
    chk(`OFS_TILT_POS, 8'h04);
    rd(`OFS_IRQ_RELEASE);
    wr(`OFS_CTRL_ONE, 8'h04);
    // tap index boundaries and random values against the two limits
    wr(`OFS_TAP_WINDOW, 8'h02);
    for (int i = 0; i < 7; i++) begin
      v = (i < 4) ? rv[7 + i / 2] + ((i % 2 == 0) ? 8'h00 : 8'h01) - ((i > 1) ? 8'h01 : 8'h00)
                  : 8'($urandom);
      tap(v);
      tick(2, 3); settle();
      chk(`OFS_IRQ_STATUS_TWO, (v > `RST_TAP_LOW && v < `RST_TAP_HIGH) ? 8'h04 : 8'h00);
      rd(`OFS_IRQ_RELEASE);
    end
    tap(8'h80);
    tap(8'h80);
    settle();
    chk(`OFS_IRQ_STATUS_TWO, 8'h08);
    rd(`OFS_IRQ_RELEASE);
    wr(`OFS_CTRL_ONE, 8'h00);
    // free-fall with irq masked, then unmasked, then pulse mode
    wr(`OFS_EVT_MASK, 8'h00);
    rd(`OFS_EVT_STATUS);
    wr(`OFS_FALL_COUNT, 8'h02);
    fall_magnitude <= 8'h07;
    tick(3, 3); settle();
    chk(`OFS_IRQ_STATUS_TWO, 8'h00);
    wr(`OFS_FALL_CTRL, 8'h80);
    fall_magnitude <= `RST_FALL_THRESH;
    tick(3, 3); settle();
    chk(`OFS_IRQ_STATUS_TWO, 8'h00);
    fall_magnitude <= 8'h07;
    tick(3, 2);
    fall_magnitude <= 8'hff;
    settle();
    cmp(irq, 1'b0);
    chk(`OFS_IRQ_STATUS_TWO, 8'h80);
    rd(`OFS_IRQ_RELEASE);
    wr(`OFS_EVT_MASK, 8'h3f); settle();
    cmp(irq, 1'b1);
    rd(`OFS_EVT_STATUS);
    wr(`OFS_IRQ_CTRL_ONE, 8'h38);
    pin_hi <= 32'h0;
    fall_magnitude <= 8'h07;
    tick(3, 2);
    fall_magnitude <= 8'hff;
    repeat (1400) @(posedge hclk);
    cmp(pin_hi, `PIN_PULSE_CYCLES);
    rd(`OFS_IRQ_RELEASE);
    complete_run();
  end
endmodule // motion_engine_interrupt_control_tb_top
bind motion_engine_interrupt_control motion_irq_checker u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout_ff(hreadyout_ff), .hrdata_ff(hrdata_ff),
  .hresp_ff(hresp_ff), .tilt_tick(tilt_tick), .wake_tick(wake_tick),
  .tap_tick(tap_tick), .fall_tick(fall_tick), .tap_strobe(tap_strobe),
  .int_pin_ff(int_pin_ff), .irq_ff(irq_ff));
`default_nettype wire
